// >>> sar_conv_ctrl.sv
// SAR ADC conversion sequencer with start, power-up wait and EOF handshake
// Function
// - Produce 12-bit results at up to 1 Msps, single-ended or differential.
// - Resolve bits by binary search from MSB to LSB against a DAC.
// - Conversion clock is 16x sample rate and never above 16 MHz.
// - Start on software start bit or on start-of-frame strobe.
// - Continuous mode converts without the start-of-frame input.
// - No conversion until 10 us after power-up or wake.
// - On completion set status and hold end-of-frame until result read.
// - End-of-frame serves as interrupt source or DMA request.
// - Single-conversion bit: one per start event, else back-to-back.
// - Continuous results drain by DMA through end-of-frame alone.
`timescale 1ns/1ps
`default_nettype none
module sar_conv_ctrl
	import sar_ctrl_pkg::*;
#(
	parameter int RES_W    = RESULT_BITS,
	parameter int DIV_W    = 8,
	parameter int PWRUP_CY = PWRUP_WAIT_CYCLES
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Power and mode control
	input  wire logic             powered,
	input  wire logic             one_shot,
	input  wire logic             diff_sel,
	input  wire logic [DIV_W-1:0] clk_div,
	// Start sources
	input  wire logic             start_bit,
	input  wire logic             sof,
	// Analog front end
	input  wire logic             cmp_out,
	output logic                  sample_hold,
	output logic                  diff_mode,
	output logic      [RES_W-1:0] dac_code,
	// Result side
	output logic                  eof,
	output logic                  done_status,
	output logic      [RES_W-1:0] result,
	input  wire logic             result_read,
	// Status
	output logic                  ready,
	output logic                  busy
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int PCW = $clog2(PWRUP_CY + 1);
	localparam int BCW = $clog2(RES_W);
	localparam int SCW = $clog2(CLKS_PER_SAMPLE);
	// Last sample-phase slot: sample, then 12 bit steps, then a done step
	localparam int SAMPLE_LAST = CLKS_PER_SAMPLE - RES_W - 2;

	// Sequencer state and counters
	conv_state_t      state;
	logic [PCW-1:0]   pwr_count;
	logic [BCW-1:0]   bit_idx;
	logic [SCW-1:0]   slot;
	logic [RES_W-1:0] trial;
	logic             tick;
	logic [DIV_W-1:0] safe_div;
	logic             start_req;
	// Buffer handshake
	logic             buf_ready;
	logic             buf_valid;
	logic [RES_W-1:0] buf_data;
	logic             push;
	logic             powered_q;
	logic             pwr_done;
	logic             take_start;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// True while a conversion occupies the sequencer
	function automatic logic in_conversion(input conv_state_t s);
		return (s != ST_POWER) && (s != ST_IDLE);
	endfunction : in_conversion

	// True on the edge that takes a start from idle
	function automatic logic start_taken(
		input conv_state_t s,
		input logic        req,
		input logic        room
	);
		return (s == ST_IDLE) && req && room;
	endfunction : start_taken

	// Divider floor keeps conversion clock at or below 16 MHz
	assign safe_div = (clk_div < DIV_W'(CONV_DIV_MIN)) ?
		DIV_W'(CONV_DIV_MIN) : clk_div;

	// Either start source, or free run in continuous mode
	assign start_req = start_bit || sof || !one_shot;

	// Result pushed into buffer at end of the bit search
	assign push = (state == ST_DONE) && tick;

	// Wait over once the counter has reached its end
	assign pwr_done = (pwr_count == PCW'(PWRUP_CY));

	// Start taken from idle only when the buffer has room
	assign take_start = start_taken(state, start_req, buf_ready);

	// ----------------------------------------
	// Conversion clock enable
	// ----------------------------------------
	// Divider runs only during a conversion, so every frame starts
	// from a cleared count and spans sixteen ticks
	sar_clk_div #(
		.DIV_W (DIV_W)
	) u_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (in_conversion(state)),
		.div      (safe_div),
		.tick     (tick)
	);

	// ----------------------------------------
	// Result buffer
	// ----------------------------------------
	// Two entries let a slow reader lag one frame without loss;
	// starts hold off while both are full
	sar_result_buf #(
		.WIDTH (RES_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_data   (trial),
		.in_ready  (buf_ready),
		.out_valid (buf_valid),
		.out_data  (buf_data),
		.out_ready (result_read && eof)
	);

	// ----------------------------------------
	// Power-up wait
	// ----------------------------------------
	// Track power edge so a wake restarts the wait
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			powered_q <= 1'b0;
		end else begin
			powered_q <= powered;
		end
	end

	// Count 10 us after power comes up
	// A drop or a fresh rise clears the count, so a wake waits in full
	always_ff @(posedge core_clk) begin
		if (sys_rst || !powered || !powered_q) begin
			pwr_count <= '0;
		end else if (!pwr_done) begin
			pwr_count <= pwr_count + PCW'(1);
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Sample phase takes the slots left over by the bit steps and the done step
	always_ff @(posedge core_clk) begin
		if (sys_rst || !powered) begin
			state   <= ST_POWER;
			bit_idx <= '0;
			slot    <= '0;
			trial   <= '0;
		end else begin
			case (state)
				ST_POWER: begin
					// Hold until the wait has run out
					if (pwr_done) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					// Stall while buffer full so no word is lost
					if (take_start) begin
						state <= ST_SAMPLE;
						slot  <= '0;
						trial <= '0;
					end
				end
				ST_SAMPLE: begin
					// Track phase, then arm the MSB trial
					if (tick) begin
						slot <= slot + SCW'(1);
						if (slot == SCW'(SAMPLE_LAST)) begin
							state   <= ST_BIT;
							bit_idx <= BCW'(RES_W - 1);
							trial   <= RES_W'(1) << (RES_W - 1);
						end
					end
				end
				ST_BIT: begin
					// One result bit per tick, MSB first
					if (tick) begin
						// Keep or drop trial bit, then try the next one
						trial[bit_idx] <= cmp_out;
						if (bit_idx == '0) begin
							state <= ST_DONE;
						end else begin
							bit_idx <= bit_idx - BCW'(1);
							trial[bit_idx - BCW'(1)] <= 1'b1;
						end
					end
				end
				ST_DONE: begin
					// Start requests seen mid-conversion are dropped
					if (tick) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Analog front end drive
	// ----------------------------------------
	// Input mode latched at start and held through the search
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			diff_mode <= 1'b0;
		end else if (take_start) begin
			diff_mode <= diff_sel;
		end
	end

	// Sample switch and trial code follow the sequencer one cycle late
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sample_hold <= 1'b0;
			dac_code    <= '0;
		end else begin
			sample_hold <= (state == ST_SAMPLE);
			dac_code    <= trial;
		end
	end

	// ----------------------------------------
	// Completion and end-of-frame
	// ----------------------------------------
	// EOF holds while a result waits; a taken read drops it one cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			eof <= 1'b0;
		end else begin
			eof <= buf_valid && !(result_read && eof);
		end
	end

	// Result shows the oldest unread word
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			result <= '0;
		end else begin
			result <= buf_data;
		end
	end

	// New completion wins over a read in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			done_status <= 1'b0;
		end else if (push) begin
			done_status <= 1'b1;
		end else if (result_read && eof) begin
			done_status <= 1'b0;
		end
	end

	// Ready while idle and past the power-up wait
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ready <= 1'b0;
		end else begin
			ready <= (state == ST_IDLE);
		end
	end

	// Busy while a conversion holds the sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy <= 1'b0;
		end else begin
			busy <= in_conversion(state);
		end
	end

endmodule : sar_conv_ctrl
`default_nettype wire

// >>> sar_ctrl_pkg.sv
// Shared constants for the SAR conversion controller
package sar_ctrl_pkg;

	// ----------------------------------------
	// Clocking and timing
	// ----------------------------------------
	localparam int CORE_CLK_MHZ       = 125;
	localparam int PWRUP_WAIT_US      = 10;
	// Exact product, no rounding: 10 us at 125 MHz
	localparam int PWRUP_WAIT_CYCLES  = PWRUP_WAIT_US * CORE_CLK_MHZ;
	localparam int CONV_CLK_MAX_MHZ   = 16;
	// Core cycles per conversion clock, rounded up so the rate stays <= 16 MHz
	localparam int CONV_DIV_MIN       =
		(CORE_CLK_MHZ + CONV_CLK_MAX_MHZ - 1) / CONV_CLK_MAX_MHZ;
	localparam int CLKS_PER_SAMPLE    = 16;

	// ----------------------------------------
	// Data layout
	// ----------------------------------------
	localparam int RESULT_BITS        = 12;
	localparam int BUF_DEPTH          = 2;

	// Conversion sequencer states
	typedef enum logic [2:0] {
		ST_POWER = 3'b000,
		ST_IDLE  = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_BIT   = 3'b011,
		ST_DONE  = 3'b100
	} conv_state_t;

endpackage : sar_ctrl_pkg

// >>> sar_clk_div.sv
// Conversion clock enable divider
`timescale 1ns/1ps
`default_nettype none
module sar_clk_div
	import sar_ctrl_pkg::*;
#(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] div,
	// Enable pulse
	output logic                  tick
);

	logic [DIV_W-1:0] count;

	// Count down, pulse once per divided period
	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == '0) begin
			count <= div - DIV_W'(1);
			tick  <= 1'b1;
		end else begin
			count <= count - DIV_W'(1);
			tick  <= 1'b0;
		end
	end

endmodule : sar_clk_div
`default_nettype wire

// >>> sar_result_buf.sv
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sar_result_buf
	import sar_ctrl_pkg::*;
#(
	parameter int WIDTH = RESULT_BITS,
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != (PW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
			end
			if (push && !pop) begin
				fill <= fill + (PW+1)'(1);
			end else if (pop && !push) begin
				fill <= fill - (PW+1)'(1);
			end
		end
	end

endmodule : sar_result_buf
`default_nettype wire

// >>> sar_conv_ctrl_props.sv
// Port checker for the SAR conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conv_ctrl_props
	import sar_ctrl_pkg::*;
#(
	parameter int RES_W = RESULT_BITS
) (
	// Clock and reset
	input wire logic             core_clk,
	input wire logic             sys_rst,
	// Watched ports
	input wire logic             powered,
	input wire logic             sample_hold,
	input wire logic             diff_mode,
	input wire logic             eof,
	input wire logic             done_status,
	input wire logic [RES_W-1:0] result,
	input wire logic             result_read,
	input wire logic             ready,
	input wire logic             busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// A read that the block takes
	sequence s_read;
		eof && result_read;
	endsequence

	// A waiting result and its flag stand until read
	a_eof_holds: assert property (eof && !result_read |=> eof)
		else $error("eof dropped without a read");
	a_result_stable: assert property (eof && !result_read |=> $stable(result))
		else $error("result changed while unread");
	a_read_drops: assert property (s_read |=> !eof)
		else $error("eof did not dip after read");
	a_status_clear: assert property ($fell(done_status) |-> $past(result_read))
		else $error("status cleared without a read");
	// Sequencing
	a_idle_busy: assert property (!(ready && busy))
		else $error("ready and busy together");
	a_sample_first: assert property ($rose(busy) |-> sample_hold)
		else $error("conversion did not open with sampling");
	a_diff_steady: assert property (busy && $past(busy) |-> $stable(diff_mode))
		else $error("input mode changed mid conversion");
	a_power_wait: assert property ($rose(powered) |=> !ready [*8])
		else $error("ready too soon after power-up");
endmodule : sar_conv_ctrl_props
bind sar_conv_ctrl sar_conv_ctrl_props #(.RES_W(RES_W)) sar_conv_ctrl_props_inst (
	.core_clk(core_clk), .sys_rst(sys_rst), .powered(powered),
	.sample_hold(sample_hold), .diff_mode(diff_mode), .eof(eof),
	.done_status(done_status), .result(result), .result_read(result_read),
	.ready(ready), .busy(busy));
`default_nettype wire

// >>> sar_reader_model.sv
// Comparator and result reader standing beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_reader_model (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Analog side
	input wire logic [11:0] ana,
	input wire logic [11:0] dac_code,
	output logic            cmp_out,
	// Result side
	input wire logic        eof,
	input wire logic [11:0] result,
	input wire logic [7:0]  rd_dly,
	output logic            result_read,
	output logic [11:0]     last_word,
	output logic [15:0]     n_words
);
	int wait_cnt;
	// Keep the trial bit while the input is at or above it
	assign cmp_out = (ana >= dac_code);
	// Read each result some cycles after eof asks for it
	always @(posedge core_clk) begin
		if (sys_rst) begin
			result_read <= 1'b0;
			wait_cnt <= 0;
			n_words <= 16'h0;
			last_word <= 12'h0;
		end else if (result_read) begin
			result_read <= 1'b0;
			wait_cnt <= 0;
			n_words <= n_words + 16'h1;
			last_word <= result;
		end else if (eof && wait_cnt >= rd_dly) begin
			result_read <= 1'b1;
		end else if (eof) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule : sar_reader_model
`default_nettype wire

// >>> sar_conv_ctrl_test.sv
// Self-checking bench for the SAR conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_conv_ctrl_test;
	import sar_ctrl_pkg::*;
	logic        core_clk, sys_rst, powered, one_shot, diff_sel;
	logic        start_bit, sof, cmp_out, sample_hold, diff_mode;
	logic        eof, done_status, result_read, ready, busy;
	logic [7:0]  clk_div, rd_dly;
	logic [11:0] dac_code, result, ana, last_word;
	logic [15:0] n_words;
	int          error_cnt, checks, cyc;

	sar_conv_ctrl #(.PWRUP_CY(20)) sar_conv_ctrl_inst (.core_clk(core_clk),
		.sys_rst(sys_rst), .powered(powered), .one_shot(one_shot),
		.diff_sel(diff_sel), .clk_div(clk_div), .start_bit(start_bit),
		.sof(sof), .cmp_out(cmp_out), .sample_hold(sample_hold),
		.diff_mode(diff_mode), .dac_code(dac_code), .eof(eof),
		.done_status(done_status), .result(result),
		.result_read(result_read), .ready(ready), .busy(busy));
	sar_reader_model sar_reader_model_inst (.core_clk(core_clk),
		.sys_rst(sys_rst), .ana(ana), .dac_code(dac_code), .cmp_out(cmp_out),
		.eof(eof), .result(result), .rd_dly(rd_dly),
		.result_read(result_read), .last_word(last_word), .n_words(n_words));

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		if (error_cnt == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run

	task automatic pulse(input logic use_sof);
		@(negedge core_clk);
		start_bit = !use_sof;
		sof = use_sof;
		@(negedge core_clk);
		start_bit = 1'b0;
		sof = 1'b0;
	endtask : pulse

	// Wait out the power-up time; an early start must be lost
	task automatic power_wait;
		logic [15:0] n;
		n = n_words;
		repeat (8) @(negedge core_clk);
		check({11'h0, ready}, 12'h0);
		pulse(1'b0);
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge core_clk);
		check({11'h0, ready}, 12'h1);
		repeat (200) @(negedge core_clk);
		check(n_words[11:0], n[11:0]);
	endtask : power_wait

	// One-shot conversion of a given input
	task automatic one_conv(input logic use_sof, input logic [11:0] v);
		logic [15:0] n;
		n = n_words;
		ana = v;
		diff_sel = v[0];
		pulse(use_sof);
		for (int i = 0; i < 300 && eof !== 1'b1; i++) @(negedge core_clk);
		check({10'h0, eof, done_status}, 12'h3);
		check({11'h0, diff_mode}, {11'h0, v[0]});
		for (int i = 0; i < 50 && n_words == n; i++) @(negedge core_clk);
		@(negedge core_clk);
		check(last_word, v);
		check({10'h0, eof, done_status}, 12'h0);
	endtask : one_conv

	// A second start mid-conversion is dropped
	task automatic mid_start;
		logic [15:0] n;
		n = n_words;
		ana = 12'h5a5;
		pulse(1'b0);
		repeat (40) @(negedge core_clk);
		check({11'h0, busy}, 12'h1);
		pulse(1'b1);
		repeat (400) @(negedge core_clk);
		check(n_words[11:0] - n[11:0], 12'h1);
	endtask : mid_start

	// Continuous run against a slow reader, then drain
	task automatic continuous;
		logic [15:0] n;
		n = n_words;
		ana = 12'h3c7;
		rd_dly = 8'd250;
		one_shot = 1'b0;
		for (int i = 0; i < 3000 && n_words < n + 16'h4; i++) @(negedge core_clk);
		one_shot = 1'b1;
		check(last_word, 12'h3c7);
		check({11'h0, n_words >= n + 16'h4}, 12'h1);
		repeat (1200) @(negedge core_clk);
		check({11'h0, eof}, 12'h0);
		rd_dly = 8'd5;
	endtask : continuous

	// Clock at 8 ns
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		powered = 1'b1;
		one_shot = 1'b1;
		diff_sel = 1'b0;
		clk_div = 8'h08;
		start_bit = 1'b0;
		sof = 1'b0;
		ana = 12'h0;
		rd_dly = 8'd5;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		power_wait();
		one_conv(1'b0, 12'ha5c);
		one_conv(1'b1, 12'hfff);
		one_conv(1'b0, 12'h000);
		one_conv(1'b1, 12'h801);
		mid_start();
		powered = 1'b0;
		repeat (5) @(negedge core_clk);
		powered = 1'b1;
		power_wait();
		continuous();
		complete_run();
	end
endmodule : sar_conv_ctrl_test
`default_nettype wire
